//--- logic/nsc_ctrl.v
// Register side of the backlight driver: readback snapshot, key lock,
// configuration-memory command register and the shadow configuration bytes.
// Assumes the serial port decoder delivers byte accesses on clk_sys and the
// live level and duty come from logic on the same clock.
//
// Behaviour
// - Level high read snapshots level and duty
// - Level split: high nibble, low byte
// - Duty split upper then lower byte
// - Idle flag low while memory busy
// - Program bit copies shadow into storage
// - Load bit copies storage into shadow
// - Three key bytes in order unlock
// - Other key write relocks; key write-only
// - Shadow zero bits 7:6 thermal knee
// - Shadow zero bits 5:4 sink bias
// - Shadow zero low nibble level high
// - Next shadow byte holds level low
`timescale 1ns/1ns
`include "nsc_defs.vh"

module nsc_ctrl #(
  parameter DEPTH = 25,
  parameter STEP_CYCLES = `NSC_STEP_CYCLES
)
(
  input wire clk_sys,
  input wire arst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [11:0] sink_level_live,
  input wire [15:0] duty_live,
  output reg [7:0] reg_rdata_reg,
  output reg reg_rvalid_reg,
  output reg unlocked_reg,
  output reg [1:0] thermal_knee_select,
  output reg [1:0] sink_bias_select,
  output reg [11:0] sink_level_setting
);

  localparam KS_LOCKED = 4'b0001;
  localparam KS_GOT1 = 4'b0010;
  localparam KS_GOT2 = 4'b0100;
  localparam KS_OPEN = 4'b1000;

  reg [3:0] key_state_reg;
  reg [3:0] key_state_next;
  reg [11:0] level_snap_reg;
  reg [15:0] duty_snap_reg;
  reg nvm_program_cmd_reg;
  reg nvm_load_cmd_reg;
  reg [7:0] shadow_mem [0:DEPTH-1];
  reg [7:0] store_mem [0:DEPTH-1];
  reg [7:0] rdata_next;
  integer i;

  wire eng_busy;
  wire step_en;
  wire step_prog;
  wire [4:0] step_idx;
  wire nvm_idle_flag;
  wire in_shadow;
  wire [7:0] shadow_off;
  wire [4:0] shadow_idx;
  wire key_wr;
  wire cmd_wr;
  wire shadow_wr;
  wire start_prog;
  wire start_load;

  // ==========================================
  // Address decode
  assign in_shadow = (reg_addr >= `NSC_ADDR_SHADOW_FIRST) &&
    (reg_addr <= `NSC_ADDR_SHADOW_LAST);
  assign shadow_off = reg_addr - `NSC_ADDR_SHADOW_FIRST;
  assign shadow_idx = shadow_off[4:0];
  assign key_wr = reg_wr && (reg_addr == `NSC_ADDR_KEY);
  assign cmd_wr = reg_wr && (reg_addr == `NSC_ADDR_COMMAND) && unlocked_reg;
  // shadow writes gated
  // Writes during a copy are dropped so the copy sees a stable image
  assign shadow_wr = reg_wr && in_shadow && unlocked_reg && !eng_busy;

  assign nvm_idle_flag = !eng_busy;

  // Start only on a 0-to-1 edge of a command bit, and only while idle
  // program start
  assign start_prog = cmd_wr && !eng_busy && reg_wdata[`NSC_BIT_PROG] &&
    !nvm_program_cmd_reg;
  assign start_load = cmd_wr && !eng_busy && !start_prog &&
    reg_wdata[`NSC_BIT_LOAD] && !nvm_load_cmd_reg;

  // ==========================================
  // Key sequence
  // ordered key match
  always @*
  begin
    key_state_next = key_state_reg;
    if (key_wr)
    begin
      if (reg_wdata == `NSC_KEY_FIRST)
        key_state_next = KS_GOT1;
      else if (key_state_reg == KS_GOT1 && reg_wdata == `NSC_KEY_SECOND)
        key_state_next = KS_GOT2;
      else if (key_state_reg == KS_GOT2 && reg_wdata == `NSC_KEY_THIRD)
        key_state_next = KS_OPEN;
      else
        key_state_next = KS_LOCKED;
    end
  end

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      key_state_reg <= KS_LOCKED;
      unlocked_reg <= 1'b0;
    end
    else
    begin
      key_state_reg <= key_state_next;
      unlocked_reg <= (key_state_next == KS_OPEN);
    end
  end

  // ==========================================
  // Command register; bits stay set until the host clears them
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      nvm_program_cmd_reg <= 1'b0;
      nvm_load_cmd_reg <= 1'b0;
    end
    else if (cmd_wr)
    begin
      nvm_program_cmd_reg <= reg_wdata[`NSC_BIT_PROG];
      nvm_load_cmd_reg <= reg_wdata[`NSC_BIT_LOAD];
    end
  end

  // ==========================================
  // Copy sequencer
  nsc_nvm_engine #(
    .DEPTH(DEPTH),
    .STEP_CYCLES(STEP_CYCLES)
  ) u_engine (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .start_prog(start_prog),
    .start_load(start_load),
    .busy_reg(eng_busy),
    .step_en_reg(step_en),
    .step_prog_reg(step_prog),
    .step_idx_reg(step_idx)
  );

  // ==========================================
  // Shadow bytes: host writes or a load step
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (i = 0; i < DEPTH; i = i + 1)
        shadow_mem[i] <= `NSC_RST_BYTE;
    end
    else if (step_en && !step_prog)
    begin
      shadow_mem[step_idx] <= store_mem[step_idx];
    end
    else if (shadow_wr)
    begin
      shadow_mem[shadow_idx] <= reg_wdata;
    end
  end

  // Storage array is not reset: it models retained contents
  always @(posedge clk_sys)
  begin
    if (step_en && step_prog)
      store_mem[step_idx] <= shadow_mem[step_idx];
  end

  // ==========================================
  // Decoded configuration outputs, registered off the shadow bytes
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      thermal_knee_select <= 2'h0;
      sink_bias_select <= 2'h0;
      sink_level_setting <= 12'h000;
    end
    else
    begin
      thermal_knee_select <= shadow_mem[0][7:6];
      sink_bias_select <= shadow_mem[0][5:4];
      sink_level_setting <= {shadow_mem[0][3:0], shadow_mem[1]};
    end
  end

  // ==========================================
  // Readback snapshot
  // latch on level high read
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      level_snap_reg <= 12'h000;
      duty_snap_reg <= 16'h0000;
    end
    else if (reg_rd && reg_addr == `NSC_ADDR_LEVEL_HI)
    begin
      level_snap_reg <= sink_level_live;
      duty_snap_reg <= duty_live;
    end
  end

  // ==========================================
  // Read mux; unmapped and write-only addresses read zero
  always @*
  begin
    rdata_next = 8'h00;
    case (reg_addr)
      `NSC_ADDR_LEVEL_HI: rdata_next = {4'h0, sink_level_live[11:8]};
      `NSC_ADDR_LEVEL_LO: rdata_next = level_snap_reg[7:0];
      `NSC_ADDR_DUTY_HI: rdata_next = duty_snap_reg[15:8];
      `NSC_ADDR_DUTY_LO: rdata_next = duty_snap_reg[7:0];
      `NSC_ADDR_COMMAND: rdata_next = {nvm_idle_flag, 5'h00,
        nvm_program_cmd_reg, nvm_load_cmd_reg};
      default:
      begin
        if (in_shadow)
          rdata_next = shadow_mem[shadow_idx];
      end
    endcase
  end

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_rdata_reg <= 8'h00;
      reg_rvalid_reg <= 1'b0;
    end
    else
    begin
      reg_rvalid_reg <= reg_rd;
      if (reg_rd)
        reg_rdata_reg <= rdata_next;
    end
  end

endmodule

//--- logic/nsc_defs.vh
// Constants for the configuration-memory shadow controller.
// Assumes a byte-wide register port with an 8-bit address.
`ifndef NSC_DEFS_VH
`define NSC_DEFS_VH

// ==========================================
// Register offsets
`define NSC_ADDR_LEVEL_HI 8'h15
`define NSC_ADDR_LEVEL_LO 8'h16
`define NSC_ADDR_DUTY_HI 8'h17
`define NSC_ADDR_DUTY_LO 8'h18
`define NSC_ADDR_COMMAND 8'h19
`define NSC_ADDR_KEY 8'h1A
`define NSC_ADDR_SHADOW_FIRST 8'h60
`define NSC_ADDR_SHADOW_LAST 8'h78

// ==========================================
// Field positions
`define NSC_BIT_IDLE 7
`define NSC_BIT_PROG 1
`define NSC_BIT_LOAD 0

// ==========================================
// Reset values and key bytes
`define NSC_RST_COMMAND 8'h80
`define NSC_RST_BYTE 8'h00
`define NSC_KEY_FIRST 8'h08
`define NSC_KEY_SECOND 8'hBA
`define NSC_KEY_THIRD 8'hEF

// ==========================================
// Timing: cycles spent per copied byte
`define NSC_STEP_CYCLES 8

`endif

//--- logic/nsc_nvm_engine.v
// Sequencer that walks the configuration bytes for a program or load.
// Assumes one-cycle start pulses that arrive only while it is idle.
`timescale 1ns/1ns

module nsc_nvm_engine #(
  parameter DEPTH = 25,
  parameter STEP_CYCLES = 8
)
(
  input wire clk_sys,
  input wire arst_n,
  input wire start_prog,
  input wire start_load,
  output reg busy_reg,
  output reg step_en_reg,
  output reg step_prog_reg,
  output reg [4:0] step_idx_reg
);

  localparam ST_IDLE = 2'b01;
  localparam ST_RUN = 2'b10;
  // Full-width end points, cut on purpose to the counter widths
  localparam [31:0] LAST_IDX_W = DEPTH - 1;
  localparam [31:0] LAST_CNT_W = STEP_CYCLES - 1;
  localparam [4:0] LAST_IDX = LAST_IDX_W[4:0];
  localparam [7:0] LAST_CNT = LAST_CNT_W[7:0];

  reg [1:0] state_reg;
  reg [7:0] cnt_reg;

  // ==========================================
  // Step sequencer: one byte copied every STEP_CYCLES
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= 8'h00;
      busy_reg <= 1'b0;
      step_en_reg <= 1'b0;
      step_prog_reg <= 1'b0;
      step_idx_reg <= 5'h00;
    end
    else
    begin
      step_en_reg <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (start_prog || start_load)
          begin
            state_reg <= ST_RUN;
            busy_reg <= 1'b1;
            step_prog_reg <= start_prog; // Program wins a tie
            step_idx_reg <= 5'h00;
            cnt_reg <= 8'h00;
          end
        end
        ST_RUN:
        begin
          if (cnt_reg == LAST_CNT)
          begin
            cnt_reg <= 8'h00;
            step_en_reg <= 1'b1;
          end
          else
          begin
            cnt_reg <= cnt_reg + 8'h01;
          end
          // Advance index the cycle after the copy strobe
          if (step_en_reg)
          begin
            if (step_idx_reg == LAST_IDX)
            begin
              state_reg <= ST_IDLE;
              busy_reg <= 1'b0;
            end
            else
            begin
              step_idx_reg <= step_idx_reg + 5'h01;
            end
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
          busy_reg <= 1'b0;
        end
      endcase
    end
  end

endmodule

//--- dv/nsc_ctrl_properties.sv
// Port checker for nsc_ctrl: readback, key lock and shadow decode.
// Assumes it is bound into nsc_ctrl and sees only its ports.
`timescale 1ns/1ns
module nsc_ctrl_chk #(
  parameter DEPTH = 25,
  parameter STEP_CYCLES = 8
)
(
  input wire clk_sys,
  input wire arst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [11:0] sink_level_live,
  input wire [15:0] duty_live,
  input wire [7:0] reg_rdata_reg,
  input wire reg_rvalid_reg,
  input wire unlocked_reg,
  input wire [1:0] thermal_knee_select,
  input wire [1:0] sink_bias_select,
  input wire [11:0] sink_level_setting
);
  reg [27:0] snap_reg;
  wire rd_hi = reg_rd && reg_addr == 8'h15;
  wire wr_key = reg_wr && reg_addr == 8'h1A;
  wire key_ef = wr_key && reg_wdata == 8'hEF;
  wire key_bad = wr_key && reg_wdata != 8'h08 && reg_wdata != 8'hBA && reg_wdata != 8'hEF;
  wire wr_s0 = reg_wr && reg_addr == 8'h60;
  wire [7:0] dec0 = {thermal_knee_select, sink_bias_select, sink_level_setting[11:8]};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // ==========================================
  // Snapshot mirror, so later reads compare with the latched pair
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      snap_reg <= 28'h0;
    else if (rd_hi)
      snap_reg <= {sink_level_live, duty_live};
  end
  // ==========================================
  // Properties
  property p_answer;
    reg_rd |=> reg_rvalid_reg;
  endproperty
  a_answer: assert property (p_answer) else $error("read not answered");
  property p_lvl_hi;
    rd_hi |=> reg_rdata_reg == {4'h0, $past(sink_level_live[11:8])};
  endproperty
  a_lvl_hi: assert property (p_lvl_hi) else $error("level high wrong");
  property p_lvl_lo;
    reg_rd && reg_addr == 8'h16 |=> reg_rdata_reg == snap_reg[23:16];
  endproperty
  a_lvl_lo: assert property (p_lvl_lo) else $error("level low wrong");
  property p_duty_hi;
    reg_rd && reg_addr == 8'h17 |=> reg_rdata_reg == snap_reg[15:8];
  endproperty
  a_duty_hi: assert property (p_duty_hi) else $error("duty high wrong");
  property p_duty_lo;
    reg_rd && reg_addr == 8'h18 |=> reg_rdata_reg == snap_reg[7:0];
  endproperty
  a_duty_lo: assert property (p_duty_lo) else $error("duty low wrong");
  property p_unlock;
    $rose(unlocked_reg) |-> $past(key_ef);
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock without key");
  property p_relock;
    key_bad |=> !unlocked_reg;
  endproperty
  a_relock: assert property (p_relock) else $error("bad key kept unlock");
  property p_locked;
    !unlocked_reg && wr_s0 |=> $stable(dec0)[*2];
  endproperty
  a_locked: assert property (p_locked) else $error("locked write took");
  property p_shadow0;
    unlocked_reg && wr_s0 |=> ##1 dec0 == $past(reg_wdata, 2);
  endproperty
  a_shadow0: assert property (p_shadow0) else $error("shadow0 decode");
  property p_shadow1;
    unlocked_reg && reg_wr && reg_addr == 8'h61 |=> ##1 sink_level_setting[7:0] == $past(reg_wdata, 2);
  endproperty
  a_shadow1: assert property (p_shadow1) else $error("shadow1 decode");
  c_unlock: cover property ($rose(unlocked_reg));
  c_snap: cover property (rd_hi);
  c_shadow: cover property (unlocked_reg && wr_s0);
endmodule

bind nsc_ctrl nsc_ctrl_chk #(.DEPTH(DEPTH), .STEP_CYCLES(STEP_CYCLES)) chk_u (
  .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .sink_level_live(sink_level_live),
  .duty_live(duty_live), .reg_rdata_reg(reg_rdata_reg), .reg_rvalid_reg(reg_rvalid_reg),
  .unlocked_reg(unlocked_reg), .thermal_knee_select(thermal_knee_select),
  .sink_bias_select(sink_bias_select), .sink_level_setting(sink_level_setting));

//--- dv/nsc_host_model.sv
// Host model: serial port reduced to byte write and read cycles.
// Assumes a read is answered by a valid pulse the cycle after it is taken.
`timescale 1ns/1ns
module nsc_host_model
(
  input wire clk_sys,
  input wire [7:0] reg_rdata_reg,
  input wire reg_rvalid_reg,
  output reg [7:0] reg_addr,
  output reg [7:0] reg_wdata,
  output reg reg_wr,
  output reg reg_rd
);
  // Idle port at time zero
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
  end
  // One write; released lines show the inverse so stale data cannot pass
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  end
  endtask
  // One read; answer taken at the edge that samples the valid pulse high
  task rd(input [7:0] a, output [7:0] d, output v);
  begin
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    reg_addr <= ~a;
    @(posedge clk_sys);
    d = reg_rdata_reg;
    v = reg_rvalid_reg;
  end
  endtask
endmodule

//--- dv/tb_nsc_ctrl.sv
// Bench for nsc_ctrl: readback snapshot, key lock, program and load.
// Assumes the host model owns the register port; copy steps are shortened.
`timescale 1ns/1ns
module tb_nsc_ctrl;
  reg clk_sys;
  reg arst_n;
  reg [11:0] lvl;
  reg [15:0] duty;
  wire [7:0] addr, wdata, rdata;
  wire wr, rd, rv, unl;
  wire [1:0] knee, bias;
  wire [11:0] setting;
  integer errors, n_compared, cyc, i;
  reg [7:0] d;
  reg v;
  // ==========================================
  // Clock, design and host
  initial
  begin
    clk_sys = 1'h0;
    forever #2 clk_sys = ~clk_sys;
  end
  nsc_ctrl #(.DEPTH(25), .STEP_CYCLES(2)) dut_u (.clk_sys(clk_sys), .arst_n(arst_n),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .sink_level_live(lvl),
    .duty_live(duty), .reg_rdata_reg(rdata), .reg_rvalid_reg(rv), .unlocked_reg(unl),
    .thermal_knee_select(knee), .sink_bias_select(bias), .sink_level_setting(setting));
  nsc_host_model host_u (.clk_sys(clk_sys), .reg_rdata_reg(rdata), .reg_rvalid_reg(rv),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd));
  // ==========================================
  // Shared tasks
  task chk(input [15:0] got, input [15:0] exp);
  begin
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task rchk(input [7:0] a, input [7:0] exp);
  begin
    host_u.rd(a, d, v);
    chk(v, 1'h1);
    chk(d, exp);
  end
  endtask
  // Shadow decode lags the write, so let it land
  task settle;
    repeat (3) @(negedge clk_sys);
  endtask
  task unlock;
  begin
    host_u.wr(8'h1A, 8'h08);
    host_u.wr(8'h1A, 8'hBA);
    host_u.wr(8'h1A, 8'hEF);
    settle;
  end
  endtask
  // Poll the idle flag; a stuck copy ends as a mismatch, not a hang
  task wait_idle(input [7:0] exp);
  begin
    for (i = 0; i < 300 && d[7] !== 1'h1; i = i + 1)
      host_u.rd(8'h19, d, v);
    chk(d, exp);
  end
  endtask
  task print_verdict;
  begin
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  // ==========================================
  // Scenarios
  task t_reset;
  begin
    rchk(8'h19, 8'h80);
    rchk(8'h17, 8'h00);
    rchk(8'h18, 8'h00);
    rchk(8'h1A, 8'h00);
  end
  endtask
  task t_snap;
  begin
    @(posedge clk_sys);
    lvl <= 12'hA5C;
    duty <= 16'h1234;
    rchk(8'h15, 8'h0A);
    @(posedge clk_sys);
    lvl <= 12'h3C1;
    duty <= 16'hFFFF;
    rchk(8'h16, 8'h5C);
    rchk(8'h17, 8'h12);
    rchk(8'h18, 8'h34);
  end
  endtask
  task t_lock;
  begin
    host_u.wr(8'h60, 8'hFF);
    host_u.wr(8'h19, 8'h01);
    settle;
    chk(setting, 12'h000);
    rchk(8'h19, 8'h80);
    host_u.wr(8'h1A, 8'h08);
    host_u.wr(8'h1A, 8'hBA);
    host_u.wr(8'h1A, 8'h55);
    host_u.wr(8'h1A, 8'hEF);
    settle;
    chk(unl, 1'h0);
    unlock;
    chk(unl, 1'h1);
    host_u.wr(8'h60, 8'h9E);
    host_u.wr(8'h61, 8'h3C);
    settle;
    chk(knee, 2'h2);
    chk(bias, 2'h1);
    chk(setting, 12'hE3C);
  end
  endtask
  task t_nvm;
  begin
    host_u.wr(8'h19, 8'h02);
    rchk(8'h19, 8'h02);
    // Shadow write during the copy must be dropped
    host_u.wr(8'h78, 8'h5A);
    wait_idle(8'h82);
    host_u.wr(8'h19, 8'h00);
    host_u.wr(8'h60, 8'h00);
    host_u.wr(8'h61, 8'h00);
    host_u.wr(8'h19, 8'h01);
    rchk(8'h19, 8'h01);
    wait_idle(8'h81);
    host_u.wr(8'h19, 8'h00);
    settle;
    chk(setting, 12'hE3C);
    chk(knee, 2'h2);
    rchk(8'h78, 8'h00);
    host_u.wr(8'h1A, 8'h00);
    settle;
    chk(unl, 1'h0);
  end
  endtask
  // ==========================================
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_sys)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      errors = errors + 1;
      print_verdict;
    end
  end
  initial
  begin
    errors = 0;
    n_compared = 0;
    cyc = 0;
    arst_n = 1'h0;
    lvl = 12'h000;
    duty = 16'h0000;
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'h1;
    t_reset;
    t_snap;
    t_lock;
    t_nvm;
    print_verdict;
  end
endmodule
